/* inc/lpcbd_regs.svh */
`ifndef LPCBD_REGS_SVH
`define LPCBD_REGS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define LPCBD_CLK_PERIOD_NS 5
`define LPCBD_TXP_NS        8
`define LPCBD_TCK_MAX_NS    100
`define LPCBD_TXP_CYC       ((`LPCBD_TXP_NS + `LPCBD_CLK_PERIOD_NS - 1) / `LPCBD_CLK_PERIOD_NS)
`define LPCBD_STOP_CYC      (`LPCBD_TCK_MAX_NS / `LPCBD_CLK_PERIOD_NS)
`define LPCBD_STABLE_CLKS   2'h2
// ----------------------------------------
// configuration
// ----------------------------------------
`define LPCBD_EIGHT_BANK    1'b1
`define LPCBD_CA_W          10
`define LPCBD_CNT_W         8
`endif

/* inc/lpcbd_pkg.sv */
`default_nettype none
package lpcbd_pkg;
    typedef enum logic [3:0] {
        CMD_NOP, CMD_MRW, CMD_MRR, CMD_REFPB, CMD_REFAB, CMD_ACT, CMD_WR, CMD_RD,
        CMD_PRE, CMD_BST, CMD_PDE, CMD_SRE, CMD_DPDE, CMD_EXIT, CMD_ILLEGAL
    } lpcbd_cmd_e;
    typedef enum logic [2:0] {MODE_RUN, MODE_PD, MODE_SREF, MODE_DPD, MODE_WAKE} lpcbd_mode_e;
    typedef struct packed {
        logic       ck1, ck2, ck3;
        logic       cs1, cs2, cke1, cke2;
        logic [9:0] ca1, ca2;
    } lpcbd_smp_s;
    typedef struct packed {
        lpcbd_mode_e mode;
        logic        cke_prev;
        logic        pend;
        logic [9:0]  ca_r;
        logic        vld;
        lpcbd_cmd_e  cmd;
        logic [2:0]  bank;
        logic [14:0] row;
        logic [11:0] col;
        logic        ap;
        logic        ab;
        logic [7:0]  ma;
        logic [7:0]  op;
        logic        ready;
        logic [1:0]  edges;
        logic [7:0]  wcnt;
        logic [7:0]  idle;
    } lpcbd_dec_s;
endpackage : lpcbd_pkg
`default_nettype wire

/* inc/lpcbd_smp_if.sv */
`default_nettype none
interface lpcbd_smp_if;
    logic       rise;
    logic       fall;
    logic       cs_n;
    logic       cke;
    logic [9:0] ca;
    modport src (output rise, fall, cs_n, cke, ca);
    modport dst (input rise, fall, cs_n, cke, ca);
endinterface : lpcbd_smp_if
`default_nettype wire

/* core/lpcbd_sampler.sv */
`default_nettype none
module lpcbd_sampler
    import lpcbd_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       sys_rst_in,
    // link pins
    input  wire logic       ck_in,
    input  wire logic       cke_in,
    input  wire logic       cs_n_in,
    input  wire logic [9:0] ca_in,
    // sampled link
    lpcbd_smp_if.src        smp
);
    import lpcbd_pkg::*;

    lpcbd_smp_s r;
    lpcbd_smp_s next_r;

    // ----------------------------------------
    // two-flop synchronisers, ck edge finder
    // ----------------------------------------
    always_comb
    begin
        next_r      = r;
        next_r.ck1  = ck_in;
        next_r.ck2  = r.ck1;
        next_r.ck3  = r.ck2;
        next_r.cs1  = cs_n_in;
        next_r.cs2  = r.cs1;
        next_r.cke1 = cke_in;
        next_r.cke2 = r.cke1;
        next_r.ca1  = ca_in;
        next_r.ca2  = r.ca1;
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            r <= '{cs1: 1'b1, cs2: 1'b1, default: '0};
        else
            r <= next_r;
    end

    // data stages match ck stages so both halves land with their edge
    assign smp.rise = r.ck2 & ~r.ck3;
    assign smp.fall = ~r.ck2 & r.ck3;
    assign smp.cs_n = r.cs2;
    assign smp.cke  = r.cke2;
    assign smp.ca   = r.ca2;
endmodule : lpcbd_sampler
`default_nettype wire

/* core/lpcbd_top.sv */
`default_nettype none
`include "lpcbd_regs.svh"
module lpcbd_top
    import lpcbd_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    // link pins
    input  wire logic        link_ck_in,
    input  wire logic        link_cke_in,
    input  wire logic        link_cs_n_in,
    input  wire logic [9:0]  link_ca_in,
    // decoded command
    output var  logic        cmd_valid_out,
    output var  lpcbd_cmd_e  cmd_out,
    output var  logic [2:0]  bank_out,
    output var  logic [14:0] row_out,
    output var  logic [11:0] col_out,
    output var  logic        auto_pre_out,
    output var  logic        all_bank_out,
    output var  logic [7:0]  mr_addr_out,
    output var  logic [7:0]  mr_op_out,
    // status
    output var  logic        ready_out,
    output var  lpcbd_mode_e mode_out
);
    import lpcbd_pkg::*;

    localparam logic [7:0] TXP_CYC  = 8'(`LPCBD_TXP_CYC);
    localparam logic [7:0] STOP_CYC = 8'(`LPCBD_STOP_CYC);

    lpcbd_smp_if sif ();

    lpcbd_sampler u_smp (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .ck_in      (link_ck_in),
        .cke_in     (link_cke_in),
        .cs_n_in    (link_cs_n_in),
        .ca_in      (link_ca_in),
        .smp        (sif.src)
    );

    lpcbd_dec_s r;
    lpcbd_dec_s next_r;
    logic [9:0] c;
    logic [9:0] f;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    always_comb
    begin
        next_r     = r;
        next_r.vld = 1'b0;
        c          = r.ca_r;
        f          = sif.ca;
        if ((r.mode == MODE_SREF || r.mode == MODE_DPD) && sif.cke)
        begin
            // enable level alone wakes, no clock edge needed
            next_r.mode     = MODE_WAKE;
            next_r.cke_prev = 1'b1;
            next_r.ready    = 1'b0;
            next_r.edges    = 2'h0;
            next_r.wcnt     = 8'h00;
            next_r.vld      = 1'b1;
            next_r.cmd      = CMD_EXIT;
        end
        else if (sif.rise)
        begin
            next_r.idle     = 8'h00;
            next_r.cke_prev = sif.cke;
            if (r.mode == MODE_WAKE && r.edges != `LPCBD_STABLE_CLKS)
                next_r.edges = r.edges + 2'h1;
            if (r.cke_prev && sif.cke)
            begin
                if (sif.cs_n || sif.ca[2:0] == 3'h7)
                begin
                    // NOP leaves mode and pending work untouched
                    next_r.vld = 1'b1;
                    next_r.cmd = CMD_NOP;
                end
                else if (r.mode == MODE_RUN && r.ready)
                begin
                    next_r.pend = 1'b1;
                    next_r.ca_r = sif.ca;
                end
                else
                begin
                    // non-NOP while waking is reported, not executed
                    next_r.vld = 1'b1;
                    next_r.cmd = CMD_ILLEGAL;
                end
            end
            else if (r.cke_prev && !sif.cke)
            begin
                next_r.vld = 1'b1;
                next_r.pend = 1'b0;
                if (sif.cs_n)
                begin
                    next_r.mode = MODE_PD;
                    next_r.cmd  = CMD_PDE;
                end
                else if (sif.ca[2:0] == 3'h3)
                begin
                    next_r.mode = MODE_DPD;
                    next_r.cmd  = CMD_DPDE;
                end
                else if (sif.ca[2:0] == 3'h4)
                begin
                    next_r.mode = MODE_SREF;
                    next_r.cmd  = CMD_SRE;
                end
                else
                    next_r.cmd = CMD_ILLEGAL;
            end
            else if (!r.cke_prev && sif.cke && r.mode == MODE_PD)
            begin
                next_r.mode  = MODE_WAKE;
                next_r.ready = 1'b0;
                next_r.edges = 2'h0;
                next_r.wcnt  = 8'h00;
                next_r.vld   = 1'b1;
                next_r.cmd   = CMD_EXIT;
            end
        end
        else if (sif.fall && r.pend)
        begin
            next_r.pend = 1'b0;
            next_r.vld  = 1'b1;
            next_r.bank = c[9:7];
            if (c[3:0] == 4'h0)
            begin
                next_r.cmd = CMD_MRW;
                next_r.ma  = {f[1:0], c[9:4]};
                next_r.op  = f[9:2];
            end
            else if (c[3:0] == 4'h8)
            begin
                next_r.cmd = CMD_MRR;
                next_r.ma  = {f[1:0], c[9:4]};
            end
            else if (c[3:0] == 4'h4)
                next_r.cmd = `LPCBD_EIGHT_BANK ? CMD_REFPB : CMD_ILLEGAL;
            else if (c[3:0] == 4'hC)
                next_r.cmd = CMD_REFAB;
            else if (c[1:0] == 2'h2)
            begin
                next_r.cmd = CMD_ACT;
                next_r.row = {f[9:8], c[6:2], f[7:0]};
            end
            else if (c[2:0] == 3'h1 || c[2:0] == 3'h5)
            begin
                next_r.cmd = c[2] ? CMD_RD : CMD_WR;
                next_r.col = {f[9:1], c[6:5], 1'b0};
                next_r.ap  = f[0];
            end
            else if (c[3:0] == 4'hB)
            begin
                next_r.cmd = CMD_PRE;
                next_r.ab  = c[4];
            end
            else if (c[3:0] == 4'h3)
                next_r.cmd = CMD_BST;
            else
                next_r.cmd = CMD_ILLEGAL;
        end
        else if (r.idle != STOP_CYC)
            next_r.idle = r.idle + 8'h01;
        if (r.mode == MODE_RUN && r.idle == STOP_CYC)
        begin
            // stopped clock with enable high: requalify on restart
            next_r.mode  = MODE_WAKE;
            next_r.ready = 1'b0;
            next_r.pend  = 1'b0;
            next_r.edges = 2'h0;
            next_r.wcnt  = 8'h00;
        end
        else if (r.mode == MODE_WAKE && r.edges == `LPCBD_STABLE_CLKS)
        begin
            if (r.idle == STOP_CYC)
                next_r.edges = 2'h0;
            else if (r.wcnt + 8'h01 >= TXP_CYC)
            begin
                next_r.mode  = MODE_RUN;
                next_r.ready = 1'b1;
            end
            else
                next_r.wcnt = r.wcnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            r <= '{mode: MODE_WAKE, cmd: CMD_NOP, default: '0};
        else
            r <= next_r;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cmd_valid_out = r.vld;
    assign cmd_out       = r.cmd;
    assign bank_out      = r.bank;
    assign row_out       = r.row;
    assign col_out       = r.col;
    assign auto_pre_out  = r.ap;
    assign all_bank_out  = r.ab;
    assign mr_addr_out   = r.ma;
    assign mr_op_out     = r.op;
    assign ready_out     = r.ready;
    assign mode_out      = r.mode;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_dec;
        sif.fall && r.pend && !(r.mode == MODE_RUN && r.idle == STOP_CYC);
    endsequence

    a_mrw_fields: assert property (s_dec ##0 r.ca_r[3:0] == 4'h0 |=> cmd_valid_out
        && cmd_out == CMD_MRW && mr_op_out == $past(sif.ca[9:2]))
        else $error("mrw fields wrong");
    a_mrr_addr: assert property (s_dec ##0 r.ca_r[3:0] == 4'h8 |=> cmd_out == CMD_MRR
        && mr_addr_out == $past({sif.ca[1:0], r.ca_r[9:4]}))
        else $error("mrr address wrong");
    a_act_row: assert property (s_dec ##0 r.ca_r[1:0] == 2'h2 |=> cmd_out == CMD_ACT
        && row_out[7:0] == $past(sif.ca[7:0]) && bank_out == $past(r.ca_r[9:7]))
        else $error("activate fields wrong");
    a_col_zero: assert property (cmd_valid_out && (cmd_out == CMD_RD || cmd_out == CMD_WR)
        |-> col_out[0] == 1'b0 && auto_pre_out == $past(sif.ca[0]))
        else $error("column bit zero or ap wrong");
    a_pre_all: assert property (s_dec ##0 r.ca_r[3:0] == 4'hB |=> all_bank_out
        == $past(r.ca_r[4]))
        else $error("precharge all flag wrong");
    a_pd_entry: assert property (sif.rise && r.cke_prev && !sif.cke && sif.cs_n
        && r.mode == MODE_RUN |=> mode_out == MODE_PD && cmd_out == CMD_PDE)
        else $error("power-down entry missed");
    a_dpd_entry: assert property (sif.rise && r.cke_prev && !sif.cke && !sif.cs_n
        && sif.ca[2:0] == 3'h3 && r.mode == MODE_RUN |=> mode_out == MODE_DPD)
        else $error("deep power-down entry missed");
    a_sref_entry: assert property (sif.rise && r.cke_prev && !sif.cke && !sif.cs_n
        && sif.ca[2:0] == 3'h4 && r.mode == MODE_RUN |=> mode_out == MODE_SREF)
        else $error("self refresh entry missed");
    a_async_exit: assert property (r.mode == MODE_SREF && sif.cke
        |=> mode_out == MODE_WAKE ##1 !ready_out)
        else $error("self refresh exit not asynchronous");
    a_wake_ready: assert property ($rose(ready_out) |-> $past(r.mode) == MODE_WAKE
        && $past(r.edges) == `LPCBD_STABLE_CLKS && $past(r.wcnt) + 8'h01 >= TXP_CYC)
        else $error("ready too early");
    a_nop_cke: assert property (cmd_valid_out && cmd_out == CMD_NOP
        |-> $past(r.cke_prev) && $past(sif.cke))
        else $error("nop with changing enable");
    a_nop_keep: assert property (sif.rise && r.cke_prev && sif.cke && sif.cs_n
        && r.mode == MODE_RUN && r.idle != STOP_CYC |=> mode_out == MODE_RUN)
        else $error("nop disturbed state");

    c_mrw: cover property (cmd_valid_out && cmd_out == CMD_MRW);
    c_act: cover property (cmd_valid_out && cmd_out == CMD_ACT);
    c_sref: cover property (mode_out == MODE_SREF ##[1:200] mode_out == MODE_WAKE);
    c_ready: cover property ($rose(ready_out));
endmodule : lpcbd_top
`default_nettype wire

/* tb/lpcbd_ctrl_model.sv */
`default_nettype none
// --------
// controller model
// --------
module lpcbd_ctrl_model
(
    // link pins
    output var logic       ck_out,
    output var logic       cke_out,
    output var logic       cs_n_out,
    output var logic [9:0] ca_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // parked clock low, select high
    initial
    begin
        ck_out   = 1'b0;
        cke_out  = 1'b1;
        cs_n_out = 1'b1;
        ca_out   = 10'h000;
    end
    // 48 ns period inside a frame, far from the limits
    task automatic frame(input logic ke, input logic cs, input logic [9:0] r,
                         input logic [9:0] f);
        cke_out  <= ke;
        cs_n_out <= cs;
        ca_out   <= r;
        #12 ck_out <= 1'b1;
        #12 ca_out <= f;
        #12 ck_out <= 1'b0;
        #12 ca_out <= ~f;  // released bus never shows stale bits
        cs_n_out <= 1'b1;  // whole frames only, none left half done
    endtask : frame
    // async wake, clock stays parked
    task automatic raise_cke();
        cke_out <= 1'b1;
    endtask : raise_cke
endmodule : lpcbd_ctrl_model
`default_nettype wire

/* tb/lpcbd_bench.sv */
`default_nettype none
module lpcbd_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import lpcbd_pkg::*;
    // --------
    // signals
    // --------
    logic        sys_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        link_ck_in, link_cke_in, link_cs_n_in;
    logic [9:0]  link_ca_in;
    logic        cmd_valid_out, auto_pre_out, all_bank_out, ready_out;
    lpcbd_cmd_e  cmd_out;
    logic [2:0]  bank_out;
    logic [14:0] row_out;
    logic [11:0] col_out;
    logic [7:0]  mr_addr_out, mr_op_out;
    lpcbd_mode_e mode_out;
    int          num_errors = 0;
    int          comparisons = 0;
    lpcbd_cmd_e  seen[$];

    always #2.5 sys_clk_in = ~sys_clk_in;

    lpcbd_top DUT (.sys_clk_in, .sys_rst_in, .link_ck_in, .link_cke_in, .link_cs_n_in,
        .link_ca_in, .cmd_valid_out, .cmd_out, .bank_out, .row_out, .col_out,
        .auto_pre_out, .all_bank_out, .mr_addr_out, .mr_op_out, .ready_out, .mode_out);
    lpcbd_ctrl_model MDL (.ck_out(link_ck_in), .cke_out(link_cke_in),
        .cs_n_out(link_cs_n_in), .ca_out(link_ca_in));

    always @(posedge sys_clk_in)
        if (cmd_valid_out === 1'b1)
            seen.push_back(cmd_out);
    // --------
    // helpers
    // --------
    task automatic end_of_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_cmd(input lpcbd_cmd_e exp);
        chk("pulses", 16'h0001, 16'(seen.size()));
        if (seen.size() > 0)
            chk("cmd", 16'(exp), 16'(seen[0]));
    endtask : chk_cmd
    // off-edge start keeps link pins clear of sampling edges
    task automatic send(input logic ke, input logic cs, input logic [9:0] r,
                        input logic [9:0] f);
        @(posedge sys_clk_in);
        #1.2;
        seen.delete();
        MDL.frame(ke, cs, r, f);
        repeat (8) @(posedge sys_clk_in);
    endtask : send
    // --------
    // scenarios
    // --------
    task automatic t_reset();
        chk("mode", 16'(MODE_WAKE), 16'(mode_out));
        chk("ready", 16'h0000, 16'(ready_out));
        chk("valid", 16'h0000, 16'(cmd_valid_out));
    endtask : t_reset
    task automatic t_wake();
        repeat (3) send(1'b1, 1'b1, 10'h155, 10'h2AA);
        chk("ready", 16'h0001, 16'(ready_out));
        chk("mode", 16'(MODE_RUN), 16'(mode_out));
    endtask : t_wake
    task automatic t_mode_regs();
        send(1'b1, 1'b0, 10'h250, 10'h0F2);
        chk_cmd(CMD_MRW);
        chk("mr addr", 16'h00A5, 16'(mr_addr_out));
        chk("mr op", 16'h003C, 16'(mr_op_out));
        send(1'b1, 1'b0, 10'h1A8, 10'h2C1);
        chk_cmd(CMD_MRR);
        chk("mr addr", 16'h005A, 16'(mr_addr_out));
        send(1'b1, 1'b0, 10'h304, 10'h155);
        chk_cmd(CMD_REFPB);
        send(1'b1, 1'b0, 10'h30C, 10'h155);
        chk_cmd(CMD_REFAB);
    endtask : t_mode_regs
    task automatic t_bank();
        send(1'b1, 1'b0, 10'h2AE, 10'h32D);
        chk_cmd(CMD_ACT);
        chk("row", 16'h6B2D, 16'(row_out));
        chk("bank", 16'h0005, 16'(bank_out));
        send(1'b1, 1'b0, 10'h1C1, 10'h34B);
        chk_cmd(CMD_WR);
        chk("col", 16'h0D2C, 16'(col_out));
        chk("auto pre", 16'h0001, 16'(auto_pre_out));
        chk("bank", 16'h0003, 16'(bank_out));
        send(1'b1, 1'b0, 10'h325, 10'h1E6);
        chk_cmd(CMD_RD);
        chk("col", 16'h079A, 16'(col_out));
        chk("auto pre", 16'h0000, 16'(auto_pre_out));
        send(1'b1, 1'b0, 10'h007, 10'h3F8);
        chk_cmd(CMD_NOP);
        chk("col", 16'h079A, 16'(col_out));
        send(1'b1, 1'b1, 10'h3F0, 10'h00F);
        chk_cmd(CMD_NOP);
        send(1'b1, 1'b0, 10'h11B, 10'h2AA);
        chk_cmd(CMD_PRE);
        chk("all bank", 16'h0001, 16'(all_bank_out));
        chk("bank", 16'h0002, 16'(bank_out));
        send(1'b1, 1'b0, 10'h00B, 10'h2AA);
        chk_cmd(CMD_PRE);
        chk("all bank", 16'h0000, 16'(all_bank_out));
        chk("bank", 16'h0000, 16'(bank_out));
        send(1'b1, 1'b0, 10'h3F3, 10'h2AA);
        chk_cmd(CMD_BST);
    endtask : t_bank
    task automatic t_clk_stop();
        repeat (30) @(posedge sys_clk_in);
        chk("mode", 16'(MODE_WAKE), 16'(mode_out));
        send(1'b1, 1'b0, 10'h2AE, 10'h32D);
        chk_cmd(CMD_ILLEGAL);
        chk("ready", 16'h0000, 16'(ready_out));
        t_wake();
        // rewrite a mode register once the clock restarts
        send(1'b1, 1'b0, 10'h020, 10'h00E);
        chk_cmd(CMD_MRW);
        chk("mr addr", 16'h0082, 16'(mr_addr_out));
        chk("mr op", 16'h0003, 16'(mr_op_out));
    endtask : t_clk_stop
    task automatic t_power_down();
        // enable drop with an unknown pattern is flagged, mode kept
        send(1'b0, 1'b0, 10'h007, 10'h2AA);
        chk_cmd(CMD_ILLEGAL);
        chk("mode", 16'(MODE_RUN), 16'(mode_out));
        send(1'b1, 1'b1, 10'h155, 10'h2AA);
        chk("pulses", 16'h0000, 16'(seen.size()));
        send(1'b0, 1'b1, 10'h155, 10'h2AA);
        chk_cmd(CMD_PDE);
        chk("mode", 16'(MODE_PD), 16'(mode_out));
        send(1'b0, 1'b1, 10'h2AA, 10'h155);
        chk("mode", 16'(MODE_PD), 16'(mode_out));
        send(1'b1, 1'b1, 10'h155, 10'h2AA);
        chk_cmd(CMD_EXIT);
        chk("ready", 16'h0000, 16'(ready_out));
        t_wake();
    endtask : t_power_down
    task automatic t_sleep(input logic [9:0] r, input lpcbd_cmd_e c, input lpcbd_mode_e m);
        send(1'b0, 1'b0, r, 10'h2AA);
        chk_cmd(c);
        chk("mode", 16'(m), 16'(mode_out));
        #1.2;
        seen.delete();
        MDL.raise_cke();
        repeat (8) @(posedge sys_clk_in);
        chk_cmd(CMD_EXIT);
        t_wake();
    endtask : t_sleep
    // --------
    // main
    // --------
    initial
    begin
        repeat (20) @(posedge sys_clk_in);
        t_reset();
        sys_rst_in <= 1'b0;
        t_wake();
        t_mode_regs();
        t_bank();
        t_clk_stop();
        t_power_down();
        t_sleep(10'h004, CMD_SRE, MODE_SREF);
        t_sleep(10'h003, CMD_DPDE, MODE_DPD);
        end_of_test();
    end
endmodule : lpcbd_bench
`default_nettype wire
